// ===== cct_pkg.sv
package cct_pkg;
    // Mode field encodings
    localparam logic [2:0] MODE_INTERVAL  = 3'h0;
    localparam logic [2:0] MODE_EXT_EVENT = 3'h1;
    localparam logic [2:0] MODE_EXT_TRIG  = 3'h2;
    localparam logic [2:0] MODE_ONE_SHOT  = 3'h3;
    localparam logic [2:0] MODE_PWM_OUT   = 3'h4;
    localparam logic [2:0] MODE_FREE_RUN  = 3'h5;
    localparam logic [2:0] MODE_PW_MEAS   = 3'h6;
    // Edge selection encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Prescaler tap codes, fxx/1 .. fxx/128
    localparam logic [2:0] CLK_DIV1  = 3'h0;
    localparam logic [2:0] CLK_DIV8  = 3'h3;
    // Counter reset and wrap values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    // Control settings bundle
    typedef struct packed {
        logic       counter_enable_bit;     // Starts counting
        logic [2:0] mode;                   // Operating mode
        logic       ext_event_clock_enable; // Count on external events
        logic [2:0] clk_sel;                // Prescaler tap
        logic [1:0] ch0_edge_sel;           // Channel 0 capture edge
        logic [1:0] ch1_edge_sel;           // Channel 1 capture edge
        logic [1:0] ext_event_edge;         // Event pin edge
        logic       ch0_capture_select;     // Channel 0 capture, not compare
        logic       ch1_capture_select;     // Channel 1 capture, not compare
    } cct_ctrl_type;
endpackage

// ===== cct_timer.sv
// How it works
// - No register access on stopped clock
// - No timer output in event count
// - No one-shot pulse when ch1 exceeds ch0
// - Early capture may read FFFFH
// - Mode codes 001, 010, 011
// - Capture only free-run or width modes
module cct_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire cct_pkg::cct_ctrl_type ctrl,
    input  wire logic [CNT_W-1:0]     ch0_wr_data,
    input  wire logic                 ch0_wr_en,
    input  wire logic [CNT_W-1:0]     ch1_wr_data,
    input  wire logic                 ch1_wr_en,
    input  wire logic                 ext_event_pin,
    input  wire logic                 ch0_capture_input,
    input  wire logic                 ch1_capture_input,
    input  wire logic                 ext_trigger_pin,
    output logic [CNT_W-1:0]          ch0_capcomp_reg,
    output logic [CNT_W-1:0]          ch1_capcomp_reg,
    output logic [CNT_W-1:0]          counter_readback_reg,
    output logic                      ch0_match_irq,
    output logic                      ch1_match_irq,
    output logic                      ch0_capture_irq,
    output logic                      ch1_capture_irq,
    output logic                      timer_output_pin
);
    // Edge detect with selectable polarity
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        logic r;
        logic f;
        r = cur & ~prev;
        f = prev & ~cur;
        edge_hit = (sel == cct_pkg::EDGE_RISE) ? r :
                   (sel == cct_pkg::EDGE_FALL) ? f :
                   (sel == cct_pkg::EDGE_BOTH) ? (r | f) : 1'b0;
    endfunction

    // Previous pin levels
    logic ev_prev_q, cap0_prev_q, cap1_prev_q, trg_prev_q;
    // Prescaler
    logic [6:0] pre_q;
    // Counter and channel registers
    logic [CNT_W-1:0] cnt_q, cnt_d, cc0_q, cc0_d, cc1_q, cc1_d;
    // Run state for one-shot and trigger modes
    logic armed_q;
    // Output flip-flop
    logic out_q, out_d;
    logic m0_q, m1_q, c0_q, c1_q;
    // Prior enable, to spot the start
    logic ce_prev_q;

    // Pin event decode
    wire ev_hit   = edge_hit(ctrl.ext_event_edge, ev_prev_q, ext_event_pin);
    wire cap0_hit = edge_hit(ctrl.ch0_edge_sel, cap0_prev_q, ch0_capture_input);
    wire cap1_hit = edge_hit(ctrl.ch1_edge_sel, cap1_prev_q, ch1_capture_input);
    wire trg_hit  = edge_hit(ctrl.ch0_edge_sel, trg_prev_q, ext_trigger_pin);
    wire mode_evc = (ctrl.mode == cct_pkg::MODE_EXT_EVENT);
    wire mode_trg = (ctrl.mode == cct_pkg::MODE_EXT_TRIG);
    wire mode_os  = (ctrl.mode == cct_pkg::MODE_ONE_SHOT);
    wire mode_cap = (ctrl.mode == cct_pkg::MODE_FREE_RUN) || (ctrl.mode == cct_pkg::MODE_PW_MEAS);
    // Prescaler tap select: divide by 2^clk_sel
    wire [7:0] tap_mask = 8'((1 << ctrl.clk_sel) - 1);
    wire pre_tick = ((({1'b0, pre_q}) & tap_mask) == 8'h00);
    // Count tick: external events when enabled or event mode
    wire use_ev = ctrl.ext_event_clock_enable | mode_evc;
    wire tick   = ctrl.counter_enable_bit & (use_ev ? ev_hit : pre_tick);
    // Fresh start of counting
    wire start  = ctrl.counter_enable_bit & ~ce_prev_q;
    // Slow clocks (event input or fxx/8 and slower) capture all ones instead of the counter on the start cycle
    wire slow_clk = use_ev | (ctrl.clk_sel >= cct_pkg::CLK_DIV8);
    wire [CNT_W-1:0] cap_val = (start && slow_clk) ? {CNT_W{1'b1}} : cnt_q;
    wire is_match0 = (cnt_q == cc0_q);
    wire is_match1 = (cnt_q == cc1_q);
    // Channel captures, only in capture modes
    wire do_cap0 = mode_cap & ctrl.ch0_capture_select & cap0_hit & ctrl.counter_enable_bit;
    wire do_cap1 = mode_cap & ctrl.ch1_capture_select & cap1_hit & ctrl.counter_enable_bit;
    // One-shot suppressed when ch1 exceeds ch0
    wire os_ok = (cc1_q <= cc0_q);

    // Counter next value
    always_comb begin
        cnt_d = cnt_q;
        if (!ctrl.counter_enable_bit) begin
            cnt_d = cct_pkg::CNT_RESET;
        end else if ((mode_trg || mode_os) && !armed_q) begin
            cnt_d = cct_pkg::CNT_RESET;
        end else if (tick) begin
            // Clear on ch0 match except free-run and width measurement
            if (is_match0 && !mode_cap) begin
                cnt_d = cct_pkg::CNT_RESET;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Channel register next values
    always_comb begin
        cc0_d = cc0_q;
        cc1_d = cc1_q;
        if (do_cap0) begin
            cc0_d = cap_val;
        end else if (ch0_wr_en) begin
            cc0_d = ch0_wr_data;
        end
        if (do_cap1) begin
            cc1_d = cap_val;
        end else if (ch1_wr_en) begin
            cc1_d = ch1_wr_data;
        end
    end

    // Timer output next value
    always_comb begin
        out_d = out_q;
        if (!ctrl.counter_enable_bit || mode_evc) begin
            out_d = 1'b0;
        end else if (mode_os && !os_ok) begin
            out_d = 1'b0;
        end else if ((mode_trg || mode_os) && armed_q && tick) begin
            if (is_match1) begin
                out_d = 1'b1;
            end
            if (is_match0) begin
                out_d = 1'b0;
            end
        end else if (!mode_trg && !mode_os && tick && is_match0) begin
            out_d = ~out_q;
        end
    end

    // Pin history and prescaler
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ev_prev_q   <= 1'b0;
            cap0_prev_q <= 1'b0;
            cap1_prev_q <= 1'b0;
            trg_prev_q  <= 1'b0;
            ce_prev_q   <= 1'b0;
            pre_q       <= 7'h00;
        end else begin
            ev_prev_q   <= ext_event_pin;
            cap0_prev_q <= ch0_capture_input;
            cap1_prev_q <= ch1_capture_input;
            trg_prev_q  <= ext_trigger_pin;
            ce_prev_q   <= ctrl.counter_enable_bit;
            pre_q       <= ctrl.counter_enable_bit ? pre_q + 7'h01 : 7'h00;
        end
    end

    // Counter and channel registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            cc0_q <= '0;
            cc1_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            cc0_q <= cc0_d;
            cc1_q <= cc1_d;
            out_q <= out_d;
        end
    end

    // Arming for trigger and one-shot modes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else if (!ctrl.counter_enable_bit || !(mode_trg || mode_os)) begin
            armed_q <= 1'b0;
        end else if (trg_hit) begin
            armed_q <= 1'b1;
        end else if (mode_os && tick && is_match0) begin
            armed_q <= 1'b0;
        end
    end

    // Interrupt pulses
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            m0_q <= 1'b0;
            m1_q <= 1'b0;
            c0_q <= 1'b0;
            c1_q <= 1'b0;
        end else begin
            m0_q <= tick & is_match0 & ~ctrl.ch0_capture_select;
            m1_q <= tick & is_match1 & ~ctrl.ch1_capture_select;
            c0_q <= do_cap0;
            c1_q <= do_cap1;
        end
    end

    // Register images come straight off core_clk flops, so no second clock can reach them
    assign ch0_capcomp_reg      = cc0_q;
    assign ch1_capcomp_reg      = cc1_q;
    assign counter_readback_reg = cnt_q;
    assign ch0_match_irq        = m0_q;
    assign ch1_match_irq        = m1_q;
    assign ch0_capture_irq      = c0_q;
    assign ch1_capture_irq      = c1_q;
    assign timer_output_pin     = out_q;

    // Output held low in event count mode
    AST_NO_OUT_EVC: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(mode_evc) |-> !timer_output_pin) else $error("output active in event count mode");
    // No pulse when ch1 above ch0
    AST_OS_SUPPRESS: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(mode_os && !os_ok) |-> !timer_output_pin) else $error("one-shot pulse despite ch1 over ch0");
    // Capture copies counter
    AST_CAP_COPY: assert property (@(posedge core_clk) disable iff (!rstn)
        do_cap0 && !start |=> ch0_capcomp_reg == $past(cnt_q)) else $error("capture value wrong");
    // No capture outside capture modes
    AST_CAP_MODE: assert property (@(posedge core_clk) disable iff (!rstn)
        !mode_cap |=> !ch0_capture_irq && !ch1_capture_irq) else $error("capture outside capture mode");
    // Early capture on slow clock yields FFFFH
    AST_EARLY_CAP: assert property (@(posedge core_clk) disable iff (!rstn)
        do_cap1 && start && slow_clk |=> ch1_capcomp_reg == cct_pkg::CNT_MAX) else $error("early capture not FFFFH");
    // Disabled counter reads zero
    AST_STOP_CLR: assert property (@(posedge core_clk) disable iff (!rstn)
        !ctrl.counter_enable_bit |=> counter_readback_reg == cct_pkg::CNT_RESET) else $error("stopped counter not zero");
endmodule

// ===== cct_pins.sv
module cct_pins (
    input  wire logic       core_clk,
    input  wire logic       ev_run,
    input  wire logic [2:0] lvl,
    output logic            ext_event_pin,
    output logic            ch0_capture_input,
    output logic            ch1_capture_input,
    output logic            ext_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Capture and trigger levels follow the bench's requests
    assign ch0_capture_input = lvl[0];
    assign ch1_capture_input = lvl[1];
    assign ext_trigger_pin   = lvl[2];
    // Event pin toggles on falling edges only while asked, low otherwise
    always @(negedge core_clk) begin
        ext_event_pin <= ev_run ? ~ext_event_pin : 1'b0;
    end
endmodule

// ===== capture_compare_timer_p_tb.sv
module capture_compare_timer_p_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [2:0] mode; logic [1:0] edge_sel; logic irq;} cct_row_type;
    logic                  core_clk, rstn, w0_en, w1_en, ev_run, m0, m1, ci0, ci1, tpin, ep, cp0, cp1, tp;
    logic [15:0]           w0, w1, cc0, cc1, cnt, a;
    logic [2:0]            lvl;
    cct_pkg::cct_ctrl_type ctrl;
    int                    err_total, total_checks, seen, hi, m0n, m1n;
    // Capture only succeeds in free-running and width modes
    cct_row_type rows [7] = '{
        '{cct_pkg::MODE_INTERVAL, cct_pkg::EDGE_RISE, 1'b0}, '{cct_pkg::MODE_EXT_EVENT, cct_pkg::EDGE_NONE, 1'b0},
        '{cct_pkg::MODE_EXT_TRIG, cct_pkg::EDGE_RISE, 1'b0}, '{cct_pkg::MODE_ONE_SHOT, cct_pkg::EDGE_RISE, 1'b0},
        '{cct_pkg::MODE_PWM_OUT, cct_pkg::EDGE_RISE, 1'b0}, '{cct_pkg::MODE_FREE_RUN, cct_pkg::EDGE_RISE, 1'b1},
        '{cct_pkg::MODE_PW_MEAS, cct_pkg::EDGE_RISE, 1'b1}};
    cct_timer cct_timer_inst (.core_clk(core_clk), .rstn(rstn), .ctrl(ctrl), .ch0_wr_data(w0), .ch0_wr_en(w0_en),
        .ch1_wr_data(w1), .ch1_wr_en(w1_en), .ext_event_pin(ep), .ch0_capture_input(cp0),
        .ch1_capture_input(cp1), .ext_trigger_pin(tp), .ch0_capcomp_reg(cc0), .ch1_capcomp_reg(cc1),
        .counter_readback_reg(cnt), .ch0_match_irq(m0), .ch1_match_irq(m1), .ch0_capture_irq(ci0),
        .ch1_capture_irq(ci1), .timer_output_pin(tpin));
    cct_pins cct_pins_inst (.core_clk(core_clk), .ev_run(ev_run), .lvl(lvl), .ext_event_pin(ep),
        .ch0_capture_input(cp0), .ch1_capture_input(cp1), .ext_trigger_pin(tp));
    // Free-running 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task summarize;
        $display("errors=%0d checks=%0d", err_total, total_checks);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Step on falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Load both compare values while stopped
    task automatic wr(input logic [15:0] d0, input logic [15:0] d1);
        w0 = d0;
        w1 = d1;
        w0_en = 1'b1;
        w1_en = 1'b1;
        cyc(1);
        w0_en = 1'b0;
        w1_en = 1'b0;
    endtask
    // Settings made while stopped, then counting enabled
    task automatic setup(input logic [2:0] md, input logic [1:0] e0, input logic [1:0] e1, input logic cs);
        ctrl = '0;
        ctrl.mode = md;
        ctrl.ch0_edge_sel = e0;
        ctrl.ch1_edge_sel = e1;
        ctrl.ch0_capture_select = cs;
        ctrl.ch1_capture_select = cs;
        ctrl.ext_event_edge = cct_pkg::EDGE_RISE;
        ctrl.ext_event_clock_enable = ev_run && (md == cct_pkg::MODE_INTERVAL);
        cyc(1);
        ctrl.counter_enable_bit = 1'b1;
    endtask
    // Count capture pulses, match pulses and output-high cycles
    task automatic watch(input int n);
        seen = 0;
        hi = 0;
        m0n = 0;
        m1n = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (ci0 === 1'b1 || ci1 === 1'b1) seen++;
            if (tpin !== 1'b0) hi++;
            if (m0 === 1'b1) m0n++;
            if (m1 === 1'b1) m1n++;
        end
    endtask
    // Main sequence
    initial begin
        {rstn, w0_en, w1_en, ev_run, lvl, w0, w1, ctrl} = '0;
        cyc(4);
        chk(cc0, 16'h0000);
        chk(cnt, 16'h0000);
        rstn = 1'b1;
        foreach (rows[i]) begin
            ctrl.counter_enable_bit = 1'b0;
            cyc(1);
            wr(16'h1234, 16'h1234);
            setup(rows[i].mode, rows[i].edge_sel, cct_pkg::EDGE_NONE, 1'b1);
            cyc(3);
            lvl[0] = 1'b1;
            watch(4);
            chk(16'(seen), 16'(rows[i].irq));
            if (!rows[i].irq) chk(cc0, 16'h1234);
            cyc(1);
            lvl = '0;
        end
        setup(cct_pkg::MODE_FREE_RUN, cct_pkg::EDGE_RISE, cct_pkg::EDGE_BOTH, 1'b1);
        cyc(3);
        lvl[1] = 1'b1;
        cyc(3);
        a = cc1;
        cyc(7);
        lvl[1] = 1'b0;
        cyc(3);
        chk(cc1 - a, 16'h000A);
        ctrl.counter_enable_bit = 1'b0;
        cyc(1);
        wr(16'h0003, 16'h0003);
        ev_run = 1'b1;
        setup(cct_pkg::MODE_EXT_EVENT, cct_pkg::EDGE_NONE, cct_pkg::EDGE_NONE, 1'b0);
        watch(40);
        chk(16'(hi), 16'h0000);
        chk(16'(m0n != 0), 16'h0001);
        // Interval mode on the event clock with equal compares drives the output
        ctrl.counter_enable_bit = 1'b0;
        cyc(1);
        wr(16'h0004, 16'h0004);
        setup(cct_pkg::MODE_INTERVAL, cct_pkg::EDGE_NONE, cct_pkg::EDGE_NONE, 1'b0);
        watch(40);
        chk(16'(hi != 0 && hi != 40), 16'h0001);
        chk(16'(m0n != 0), 16'h0001);
        ev_run = 1'b0;
        ctrl.counter_enable_bit = 1'b0;
        cyc(1);
        wr(16'h0005, 16'h0009);
        setup(cct_pkg::MODE_ONE_SHOT, cct_pkg::EDGE_RISE, cct_pkg::EDGE_NONE, 1'b0);
        cyc(2);
        lvl[2] = 1'b1;
        watch(40);
        chk(16'(hi), 16'h0000);
        chk(16'(m1n), 16'h0000);
        // Ch1 below ch0 gives one pulse from the ch1 match to the ch0 match
        ctrl.counter_enable_bit = 1'b0;
        lvl = '0;
        cyc(1);
        wr(16'h0009, 16'h0005);
        setup(cct_pkg::MODE_ONE_SHOT, cct_pkg::EDGE_RISE, cct_pkg::EDGE_NONE, 1'b0);
        cyc(2);
        lvl[2] = 1'b1;
        watch(40);
        chk(16'(hi), 16'h0004);
        chk(16'(m1n), 16'h0001);
        // Capture in the first enabled cycle on a slow tap reads all ones
        ctrl.counter_enable_bit = 1'b0;
        lvl = '0;
        cyc(1);
        ctrl = '0;
        ctrl.mode = cct_pkg::MODE_FREE_RUN;
        ctrl.ch1_edge_sel = cct_pkg::EDGE_RISE;
        ctrl.ch1_capture_select = 1'b1;
        ctrl.clk_sel = cct_pkg::CLK_DIV8;
        cyc(1);
        ctrl.counter_enable_bit = 1'b1;
        lvl[1] = 1'b1;
        cyc(2);
        chk(cc1, 16'hFFFF);
        summarize();
    end
    // Hang guard, well beyond the few hundred cycles needed
    initial begin
        #100000;
        err_total++;
        summarize();
    end
endmodule
